//--- core/ccr_control_regs.sv
// Host register bank of the correlator accumulator card behind an AXI4-Lite slave
`timescale 1ns/1ns
module ccr_control_regs
	import ccr_pkg::*;
(
	// Clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_b_i,
	// AXI4-Lite write address and data
	input  wire logic [CCR_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [CCR_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// AXI4-Lite read
	input  wire logic [CCR_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [CCR_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Accumulator FPGA configuration
	output logic                       fpga_reset_b_o,
	output logic                       cfg_clk_o,
	output logic                       cfg_data_o,
	input  wire logic [1:0]            fpga_done_i,
	// Remote correlator card control link
	output logic                       rcw_clk_o,
	output logic                       rcw_data_o,
	output logic                       rcw_latch_o,
	// Card control and crossbar
	output logic [CCR_REG_W-1:0]       card_ctrl_o,
	output logic [3:0]                 xbar_out_line_o,
	output logic [3:0]                 xbar_in_line_o,
	output logic                       xbar_load_o,
	output logic                       xbar_reset_o,
	// Event lines and array controls
	input  wire logic [15:0]           event_lines_i,
	input  wire logic                  auto_blank_i,
	output logic                       array_blank_o,
	output logic                       shift_enable_o,
	output logic                       integration_control_o,
	output logic                       acc_reset_o,
	// Result bus buffer enable
	input  wire logic                  card_access_i,
	output logic                       result_bus_oe_o,
	// Windowed read into accumulator memory or correlator ICs
	output logic                       ext_rd_req_o,
	output logic                       ext_mem_sel_o,
	output logic [31:0]                ext_rd_addr_o,
	output logic [3:0]                 ext_ic_sel_o,
	input  wire logic                  ext_rd_ack_i,
	input  wire logic [31:0]           ext_rd_data_i
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [15:0]   csr_q;
	logic [7:0]    xbar_q;
	logic [15:0]   evt_q;
	logic [15:0]   rcw_pend_q;
	logic [15:0]   rcw_live_q;
	logic [31:0]   addr_q;
	logic [31:0]   word_q;
	logic [7:0]    rst_cnt_q;
	logic          cfg_busy;
	logic          rcw_busy;
	logic          rcw_done;

	// ----------------------------------------------------------------
	// Pin synchronisers: event lines, automatic blank, done lines
	// ----------------------------------------------------------------
	logic [18:0]   pin_s1_q;
	logic [18:0]   pin_s2_q;
	logic [18:0]   pin_s3_q;
	logic [18:0]   pin_q;

	// Three stages; a change counts only once stages two and three agree
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			pin_s1_q <= 19'h00000;
			pin_s2_q <= 19'h00000;
			pin_s3_q <= 19'h00000;
			pin_q    <= 19'h00000;
		end
		else
		begin
			pin_s1_q <= {fpga_done_i, auto_blank_i, event_lines_i};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q    <= (~(pin_s2_q ^ pin_s3_q) & pin_s3_q) | ((pin_s2_q ^ pin_s3_q) & pin_q);
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	logic          aw_full_q;
	logic          w_full_q;
	logic [3:0]    aw_idx_q;
	logic          aw_ok_q;
	logic [31:0]   wdat_q;
	logic [3:0]    wstb_q;
	logic          wr_fire;
	logic [15:0]   wmask;
	logic          unlocked;

	// Address and data are held independently, so either may arrive first
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready  = !w_full_q;
	assign wr_fire       = aw_full_q && w_full_q && !s_axi_bvalid;
	assign wmask         = {{8{wstb_q[1]}}, {8{wstb_q[0]}}};
	assign unlocked      = csr_q[CCR_CSR_UNLOCK];

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			aw_full_q    <= 1'b0;
			w_full_q     <= 1'b0;
			aw_idx_q     <= 4'h0;
			aw_ok_q      <= 1'b0;
			wdat_q       <= 32'h0000_0000;
			wstb_q       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CCR_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_q <= 1'b1;
				aw_idx_q  <= s_axi_awaddr[5:2];
				aw_ok_q   <= (s_axi_awaddr[7:6] == 2'h0) && (s_axi_awaddr[5:2] <= CCR_IDX_DATA_HI);
			end
			else if (wr_fire)
				aw_full_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_q <= 1'b1;
				wdat_q   <= s_axi_wdata;
				wstb_q   <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_full_q <= 1'b0;
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= aw_ok_q ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Per-register write strobes, lanes masked by wstrb
	logic          wr_csr;
	logic          wr_xbar;
	logic          wr_load;
	logic          wr_data;
	logic          wr_rcw;
	logic          wr_evt;
	logic          wr_alo;
	logic          wr_ahi;
	logic [15:0]   wval;

	assign wval    = wdat_q[15:0] & wmask;
	assign wr_csr  = wr_fire && aw_ok_q && (aw_idx_q == CCR_IDX_CARD_CSR);
	assign wr_xbar = wr_fire && aw_ok_q && (aw_idx_q == CCR_IDX_XBAR);
	assign wr_load = wr_fire && aw_ok_q && (aw_idx_q == CCR_IDX_LOAD_CTL);
	assign wr_data = wr_fire && aw_ok_q && (aw_idx_q == CCR_IDX_LOAD_DAT);
	assign wr_rcw  = wr_fire && aw_ok_q && (aw_idx_q == CCR_IDX_RCW);
	assign wr_evt  = wr_fire && aw_ok_q && (aw_idx_q == CCR_IDX_EVT_SEL);
	assign wr_alo  = wr_fire && aw_ok_q && (aw_idx_q == CCR_IDX_ADDR_LO);
	assign wr_ahi  = wr_fire && aw_ok_q && (aw_idx_q == CCR_IDX_ADDR_HI);

	// ----------------------------------------------------------------
	// Card control, crossbar and event select
	// ----------------------------------------------------------------
	// Serial number clock bit is masked off on every write and is never stored
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			csr_q <= CCR_CSR_RST;
		else if (wr_csr)
			csr_q <= ((csr_q & ~wmask) | wval) & 16'h7FFF;
	end
	assign card_ctrl_o   = csr_q;
	assign ext_mem_sel_o = csr_q[CCR_CSR_MEM_SEL];

	// A write without the reset bit applies one route; with it set, reset is pulsed instead of load
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			xbar_q       <= CCR_XBAR_RST;
			xbar_load_o  <= 1'b0;
			xbar_reset_o <= 1'b0;
		end
		else
		begin
			xbar_load_o  <= wr_xbar && !wval[CCR_XBAR_RESET];
			xbar_reset_o <= wr_xbar && wval[CCR_XBAR_RESET];
			if (wr_xbar)
				xbar_q <= wval[7:0];
		end
	end
	assign xbar_out_line_o = xbar_q[3:0];
	assign xbar_in_line_o  = xbar_q[7:4];

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			evt_q <= CCR_EVT_RST;
		else if (wr_evt)
			evt_q <= (evt_q & ~wmask) | wval;
	end

	// Each control follows the event line its nibble names; array blank also ORs in auto blank
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			array_blank_o         <= 1'b0;
			shift_enable_o        <= 1'b0;
			integration_control_o <= 1'b0;
			acc_reset_o           <= 1'b0;
		end
		else
		begin
			array_blank_o         <= pin_q[evt_q[CCR_EVT_BLANK +: 4]] | pin_q[16];
			shift_enable_o        <= pin_q[evt_q[CCR_EVT_SHIFT +: 4]];
			integration_control_o <= pin_q[evt_q[CCR_EVT_INTEG +: 4]];
			acc_reset_o           <= pin_q[evt_q[CCR_EVT_ACCRST +: 4]];
		end
	end

	// ----------------------------------------------------------------
	// Accumulator FPGA reset and configuration load
	// ----------------------------------------------------------------
	// Load controls are dead while the unlock bit is clear, guarding stray writes
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			rst_cnt_q <= 8'h00;
		else if (wr_load && unlocked && wval[CCR_LD_RESET])
			rst_cnt_q <= 8'(CCR_RST_CYC);
		else if (rst_cnt_q != 8'h00)
			rst_cnt_q <= rst_cnt_q - 8'h01;
	end
	assign fpga_reset_b_o = (rst_cnt_q == 8'h00);

	// Word arrives in a single 16-bit write and leaves MSB first
	ccr_serial_shifter u_cfg_shift (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.start_i    (wr_data && unlocked),
		.word_i     (wval),
		.busy_o     (cfg_busy),
		.done_o     (),
		.ser_clk_o  (cfg_clk_o),
		.ser_data_o (cfg_data_o)
	);

	// ----------------------------------------------------------------
	// Remote correlator card control word
	// ----------------------------------------------------------------
	// Latest write waits here if a previous word is still on the link
	logic          rcw_pend_v_q;
	// Copy of the word actually on the link, so a queued write cannot show early
	logic [15:0]   rcw_sent_q;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			rcw_sent_q   <= CCR_RCW_RST;
			rcw_pend_q   <= CCR_RCW_RST;
			rcw_pend_v_q <= 1'b0;
			rcw_live_q   <= CCR_RCW_RST;
			rcw_latch_o  <= 1'b0;
		end
		else
		begin
			rcw_latch_o <= rcw_done;
			if (wr_rcw)
			begin
				rcw_pend_q   <= wval;
				rcw_pend_v_q <= 1'b1;
			end
			else if (!rcw_busy)
				rcw_pend_v_q <= 1'b0;
			if (rcw_pend_v_q && !rcw_busy)
				rcw_sent_q <= rcw_pend_q;
			if (rcw_done)
				rcw_live_q <= rcw_sent_q;
		end
	end

	ccr_serial_shifter u_rcw_shift (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.start_i    (rcw_pend_v_q),
		.word_i     (rcw_pend_q),
		.busy_o     (rcw_busy),
		.done_o     (rcw_done),
		.ser_clk_o  (rcw_clk_o),
		.ser_data_o (rcw_data_o)
	);

	// Result bus may only open once the disable bit shown to the card is clear
	assign result_bus_oe_o = card_access_i && !rcw_live_q[CCR_RCW_BUS_DIS];

	// ----------------------------------------------------------------
	// Read window address
	// ----------------------------------------------------------------
	logic          rd_hi_take;

	// A host write to the address wins over a same-cycle increment
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			addr_q <= CCR_ADDR_RST;
		else if (wr_alo)
			addr_q[15:0] <= (addr_q[15:0] & ~wmask) | wval;
		else if (wr_ahi)
			addr_q[31:16] <= (addr_q[31:16] & ~wmask) | wval;
		else if (rd_hi_take && csr_q[CCR_CSR_MEM_SEL])
			addr_q <= addr_q + 32'h0000_0001;
	end
	assign ext_rd_addr_o = addr_q;
	assign ext_ic_sel_o  = addr_q[3:0];

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	ccr_rd_state_t rd_st_q;
	logic [31:0]   rmux;
	logic          ar_ok;
	logic [3:0]    ar_idx;

	assign s_axi_arready = (rd_st_q == CCR_RD_IDLE);
	assign ar_idx        = s_axi_araddr[5:2];
	assign ar_ok         = (s_axi_araddr[7:6] == 2'h0) && (ar_idx <= CCR_IDX_DATA_HI);
	assign rd_hi_take    = s_axi_arvalid && s_axi_arready && ar_ok && (ar_idx == CCR_IDX_DATA_HI);
	assign ext_rd_req_o  = (rd_st_q == CCR_RD_EXT);

	// Read value of each register; write-only and reserved bits read zero
	always_comb
	begin
		rmux = 32'h0000_0000;
		case (ar_idx)
			CCR_IDX_CARD_CSR: rmux = {16'h0000, csr_q};
			CCR_IDX_XBAR:     rmux = {24'h00_0000, xbar_q};
			CCR_IDX_LOAD_CTL: rmux = {30'h0000_0000, cfg_busy, !fpga_reset_b_o};
			CCR_IDX_LOAD_DAT: rmux = {30'h0000_0000, pin_q[18:17]};
			CCR_IDX_EVT_SEL:  rmux = {16'h0000, evt_q};
			CCR_IDX_ADDR_LO:  rmux = {16'h0000, addr_q[15:0]};
			CCR_IDX_ADDR_HI:  rmux = {16'h0000, addr_q[31:16]};
			CCR_IDX_DATA_HI:  rmux = {16'h0000, word_q[31:16]};
			default:          rmux = 32'h0000_0000;
		endcase
	end

	// The low data read fetches the word; the high read returns its held upper half
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			rd_st_q      <= CCR_RD_IDLE;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= CCR_RESP_OKAY;
			word_q       <= 32'h0000_0000;
		end
		else
		begin
			case (rd_st_q)
				CCR_RD_IDLE:
				begin
					if (s_axi_arvalid)
					begin
						if (ar_ok && (ar_idx == CCR_IDX_DATA_LO))
							rd_st_q <= CCR_RD_EXT;
						else
						begin
							rd_st_q      <= CCR_RD_RESP;
							s_axi_rvalid <= 1'b1;
							s_axi_rdata  <= ar_ok ? rmux : 32'h0000_0000;
							s_axi_rresp  <= ar_ok ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
						end
					end
				end
				CCR_RD_EXT:
				begin
					if (ext_rd_ack_i)
					begin
						word_q       <= ext_rd_data_i;
						s_axi_rdata  <= {16'h0000, ext_rd_data_i[15:0]};
						s_axi_rresp  <= CCR_RESP_OKAY;
						s_axi_rvalid <= 1'b1;
						rd_st_q      <= CCR_RD_RESP;
					end
				end
				CCR_RD_RESP:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid <= 1'b0;
						rd_st_q      <= CCR_RD_IDLE;
					end
				end
				default:
					rd_st_q <= CCR_RD_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence load_reset_write_s;
		wr_load && unlocked && wval[CCR_LD_RESET];
	endsequence

	fpga_reset_pulse_a: assert property (load_reset_write_s |=> !fpga_reset_b_o [*8])
		else $error("fpga reset pulse too short");

	reset_busy_read_a: assert property ((s_axi_arvalid && s_axi_arready && ar_idx == CCR_IDX_LOAD_CTL && ar_ok)
		|=> s_axi_rdata[0] == $past(!fpga_reset_b_o))
		else $error("reset busy flag misread");

	cfg_busy_start_a: assert property ((wr_data && unlocked && !cfg_busy) |=> cfg_busy ##1 cfg_busy)
		else $error("configuration shift did not start");

	locked_load_a: assert property ((wr_data && !unlocked && !cfg_busy) |=> !cfg_busy)
		else $error("configuration shift started while locked");

	done_read_a: assert property ((s_axi_arvalid && s_axi_arready && ar_idx == CCR_IDX_LOAD_DAT && ar_ok)
		|=> s_axi_rdata[1:0] == $past(pin_q[18:17]))
		else $error("done flags misread");

	bus_disable_a: assert property (rcw_live_q[CCR_RCW_BUS_DIS] |-> !result_bus_oe_o)
		else $error("result bus enabled while disabled");

	rcw_apply_a: assert property (rcw_done |=> rcw_latch_o && rcw_live_q == $past(rcw_sent_q))
		else $error("remote word not applied");

	blank_or_a: assert property (##1 array_blank_o == ($past(pin_q[16]) || $past(pin_q[evt_q[3:0]])))
		else $error("blank not ORed with auto blank");

	addr_incr_a: assert property ((rd_hi_take && ext_mem_sel_o && !wr_alo && !wr_ahi)
		|=> addr_q == $past(addr_q) + 32'h0000_0001)
		else $error("read address did not increment");

	ic_addr_hold_a: assert property ((rd_hi_take && !ext_mem_sel_o && !wr_alo && !wr_ahi) |=> $stable(addr_q))
		else $error("address moved in IC mode");

	xbar_reset_a: assert property ((wr_xbar && wval[CCR_XBAR_RESET]) |=> xbar_reset_o && !xbar_load_o)
		else $error("crossbar reset not issued");

endmodule : ccr_control_regs

//--- core/ccr_serial_shifter.sv
// Sixteen-bit parallel to serial shifter with its own generated serial clock
`timescale 1ns/1ns
module ccr_serial_shifter
	import ccr_pkg::*;
(
	// Clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_b_i,
	// Parallel side
	input  wire logic                 start_i,
	input  wire logic [CCR_REG_W-1:0] word_i,
	output logic                      busy_o,
	output logic                      done_o,
	// Serial side
	output logic                      ser_clk_o,
	output logic                      ser_data_o
);

	logic [CCR_REG_W-1:0] shift_q;
	logic [7:0]           div_q;
	logic [4:0]           bits_q;
	logic                 tick;

	// Half-period tick of the serial clock
	assign tick = busy_o && (div_q == 8'(CCR_SER_HALF_CYC - 1));

	// Divider runs only while a word is in flight
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i || !busy_o || tick)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// MSB leaves first; data moves on the falling edge so the target samples it mid-bit
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			busy_o     <= 1'b0;
			done_o     <= 1'b0;
			ser_clk_o  <= 1'b0;
			ser_data_o <= 1'b0;
			shift_q    <= 16'h0000;
			bits_q     <= 5'h00;
		end
		else
		begin
			done_o <= 1'b0;
			if (!busy_o && start_i)
			begin
				busy_o     <= 1'b1;
				ser_data_o <= word_i[CCR_REG_W-1];
				shift_q    <= {word_i[CCR_REG_W-2:0], 1'b0};
				bits_q     <= 5'h00;
			end
			else if (tick)
			begin
				ser_clk_o <= ~ser_clk_o;
				if (ser_clk_o)
				begin
					if (bits_q == 5'(CCR_REG_W - 1))
					begin
						busy_o <= 1'b0;
						done_o <= 1'b1;
					end
					ser_data_o <= shift_q[CCR_REG_W-1];
					shift_q    <= {shift_q[CCR_REG_W-2:0], 1'b0};
					bits_q     <= bits_q + 5'h01;
				end
			end
		end
	end

endmodule : ccr_serial_shifter

//--- pkg/ccr_pkg.sv
// Shared constants and types for the correlator card control register block
package ccr_pkg;

	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int          CCR_ADDR_W       = 8;
	localparam int          CCR_DATA_W       = 32;
	localparam int          CCR_REG_W        = 16;
	localparam logic [1:0]  CCR_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  CCR_RESP_SLVERR  = 2'h2;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [3:0]  CCR_IDX_CARD_CSR = 4'h0;
	localparam logic [3:0]  CCR_IDX_XBAR     = 4'h1;
	localparam logic [3:0]  CCR_IDX_LOAD_CTL = 4'h2;
	localparam logic [3:0]  CCR_IDX_LOAD_DAT = 4'h3;
	localparam logic [3:0]  CCR_IDX_RCW      = 4'h4;
	localparam logic [3:0]  CCR_IDX_EVT_SEL  = 4'h5;
	localparam logic [3:0]  CCR_IDX_ADDR_LO  = 4'h6;
	localparam logic [3:0]  CCR_IDX_ADDR_HI  = 4'h7;
	localparam logic [3:0]  CCR_IDX_DATA_LO  = 4'h8;
	localparam logic [3:0]  CCR_IDX_DATA_HI  = 4'h9;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          CCR_CSR_MEM_SEL  = 1;
	localparam int          CCR_CSR_UNLOCK   = 13;
	localparam int          CCR_CSR_SN_CLK   = 15;
	localparam int          CCR_LD_RESET     = 0;
	localparam int          CCR_LD_SHIFTING  = 1;
	localparam int          CCR_XBAR_RESET   = 15;
	localparam int          CCR_RCW_BUS_DIS  = 12;
	localparam int          CCR_EVT_BLANK    = 0;
	localparam int          CCR_EVT_SHIFT    = 4;
	localparam int          CCR_EVT_INTEG    = 8;
	localparam int          CCR_EVT_ACCRST   = 12;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] CCR_CSR_RST      = 16'h0000;
	localparam logic [7:0]  CCR_XBAR_RST     = 8'h00;
	localparam logic [15:0] CCR_EVT_RST      = 16'h0000;
	localparam logic [15:0] CCR_RCW_RST      = 16'h0000;
	localparam logic [31:0] CCR_ADDR_RST     = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CCR_CLK_NS       = 40;
	localparam int          CCR_RST_PULSE_NS = 1000;
	localparam int          CCR_SER_HALF_NS  = 200;
	localparam int          CCR_RST_CYC      = (CCR_RST_PULSE_NS + CCR_CLK_NS - 1) / CCR_CLK_NS;
	localparam int          CCR_SER_HALF_CYC = (CCR_SER_HALF_NS + CCR_CLK_NS - 1) / CCR_CLK_NS;

	// Read channel sequencing
	typedef enum logic [1:0] {
		CCR_RD_IDLE,
		CCR_RD_EXT,
		CCR_RD_RESP
	} ccr_rd_state_t;

endpackage : ccr_pkg

//--- testbench/ccr_ext_read_model.sv
// Far-side model of accumulator memory and correlator ICs answering window reads
`timescale 1ns/1ns
module ccr_ext_read_model
	import ccr_pkg::*;
(
	// Clock and request side
	input  wire logic        core_clk_i,
	input  wire logic        ext_rd_req_i,
	input  wire logic        ext_mem_sel_i,
	input  wire logic [31:0] ext_rd_addr_i,
	input  wire logic [3:0]  ext_ic_sel_i,
	// Answer side
	output logic             ext_rd_ack_o,
	output logic [31:0]      ext_rd_data_o
);
	logic [3:0] wait_q = 4'h0;
	logic       slow_q = 1'b0;
	// Alternate quick and slow answers; data only valid with ack, noise otherwise
	always @(posedge core_clk_i)
	begin
		ext_rd_ack_o  <= 1'b0;
		ext_rd_data_o <= ~ext_rd_data_o;
		wait_q        <= ext_rd_req_i ? wait_q + 4'h1 : 4'h0;
		if (ext_rd_req_i && !ext_rd_ack_o && wait_q == (slow_q ? 4'h6 : 4'h0))
		begin
			ext_rd_ack_o  <= 1'b1;
			slow_q        <= !slow_q;
			ext_rd_data_o <= ext_mem_sel_i ? ext_rd_addr_i ^ 32'h5A5AA5A5 : {28'h0, ext_ic_sel_i};
		end
	end
endmodule : ccr_ext_read_model

//--- testbench/tb_correlator_card_control_regs.sv
// Self-checking bench for the correlator card control register block
`timescale 1ns/1ns
module tb_correlator_card_control_regs
	import ccr_pkg::*;
;
	logic clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, ack, awr, wr_r, bv, arr, rv, req, msel, blk, sh, ig, ar, oe;
	logic ab = 1'b0, frb, cck, cdt, rck, rdt;
	logic [7:0] aa = 8'h00, ra = 8'h00;
	logic [31:0] wd = 32'h0, rd_d, ea, edat, st = 32'd70, a, m;
	logic [1:0] br, rr, done = 2'h0;
	logic [3:0] ics;
	logic [15:0] ev = 16'h0, r, cw, rw;
	logic [33:0] q[$], e;
	int err_count = 0, tests_run = 0;
	always #20 clk = ~clk;
	ccr_control_regs u_dut (.core_clk_i(clk), .rst_b_i(rst_b), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ra), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
		.fpga_reset_b_o(frb), .cfg_clk_o(cck), .cfg_data_o(cdt), .fpga_done_i(done), .rcw_clk_o(rck), .rcw_data_o(rdt),
		.rcw_latch_o(), .card_ctrl_o(), .xbar_out_line_o(), .xbar_in_line_o(), .xbar_load_o(), .xbar_reset_o(),
		.event_lines_i(ev), .auto_blank_i(ab), .array_blank_o(blk), .shift_enable_o(sh),
		.integration_control_o(ig), .acc_reset_o(ar), .card_access_i(1'b1), .result_bus_oe_o(oe),
		.ext_rd_req_o(req), .ext_mem_sel_o(msel), .ext_rd_addr_o(ea), .ext_ic_sel_o(ics),
		.ext_rd_ack_i(ack), .ext_rd_data_i(edat));
	ccr_ext_read_model u_mem (.core_clk_i(clk), .ext_rd_req_i(req), .ext_mem_sel_i(msel), .ext_rd_addr_i(ea),
		.ext_ic_sel_i(ics), .ext_rd_ack_o(ack), .ext_rd_data_o(edat));
	// Far-side capture of both serial links, one bit per rising serial clock
	always @(posedge cck) cw <= {cw[14:0], cdt};
	always @(posedge rck) rw <= {rw[14:0], rdt};
	// Pin-level compare; values are taken when the task is called, compared at the next falling edge
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		@(negedge clk);
		tests_run++;
		if (g !== x)
		begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	task automatic complete_run();
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	// Write with address and data offered together, each released when taken
	task automatic wr(input logic [3:0] i, input logic [31:0] d);
		logic ta, tw;
		@(posedge clk);
		aa <= {2'h0, i, 2'h0}; wd <= d; awv <= 1'b1; wv <= 1'b1;
		do begin
			@(negedge clk); ta = awv && awr; tw = wv && wr_r;
			@(posedge clk); if (ta) awv <= 1'b0; if (tw) wv <= 1'b0;
		end while ((awv && !ta) || (wv && !tw));
		do @(negedge clk); while (!bv);
	endtask : wr
	// Read notes the expected response, the watcher below compares it
	task automatic rd(input logic [7:0] b, input logic [33:0] x);
		q.push_back(x);
		@(posedge clk);
		ra <= b; arv <= 1'b1;
		do @(negedge clk); while (!arr);
		@(posedge clk); arv <= 1'b0;
		do @(negedge clk); while (!rv);
		@(posedge clk);
	endtask : rd
	always @(posedge clk)
		if (rv)
		begin
			e = q.pop_front(); tests_run++;
			if ({rr, rd_d} !== e)
			begin
				err_count++;
				$display("FAIL t=%0t got=%h exp=%h", $time, {rr, rd_d}, e);
			end
		end
	initial begin #2000000 err_count++; complete_run(); end
	initial
	begin
		r = 16'(xs(st)); done <= r[1:0]; ev <= r;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		wr(CCR_IDX_EVT_SEL, {16'h0, r}); rd({2'h0, CCR_IDX_EVT_SEL, 2'h0}, {18'h0, r});
		chk({blk, sh, ig, ar}, {r[r[3:0]], r[r[7:4]], r[r[11:8]], r[r[15:12]]});
		ev <= 16'h0; ab <= 1'b1; repeat (8) @(posedge clk);
		chk({blk, sh, ig, ar}, 4'h8);
		$display("event select done");
		wr(CCR_IDX_LOAD_CTL, 32'h1); wr(CCR_IDX_LOAD_DAT, 32'h1234); rd({2'h0, CCR_IDX_LOAD_CTL, 2'h0}, 34'h0);
		wr(CCR_IDX_XBAR, 32'h8000); wr(CCR_IDX_XBAR, 32'hFD); rd({2'h0, CCR_IDX_XBAR, 2'h0}, 34'hFD);
		wr(CCR_IDX_CARD_CSR, 32'h2002); a = 32'h0001FFFF;
		wr(CCR_IDX_ADDR_LO, 32'hFFFF); wr(CCR_IDX_ADDR_HI, 32'h1);
		repeat (2)
		begin
			m = a ^ 32'h5A5AA5A5;
			rd({2'h0, CCR_IDX_DATA_LO, 2'h0}, {18'h0, m[15:0]});
			rd({2'h0, CCR_IDX_DATA_HI, 2'h0}, {18'h0, m[31:16]});
			a++;
		end
		wr(CCR_IDX_CARD_CSR, 32'h2000);
		rd({2'h0, CCR_IDX_DATA_LO, 2'h0}, {30'h0, a[3:0]});
		rd({2'h0, CCR_IDX_DATA_HI, 2'h0}, 34'h0);
		rd({2'h0, CCR_IDX_ADDR_LO, 2'h0}, {18'h0, a[15:0]});
		$display("window reads done");
		wr(CCR_IDX_LOAD_CTL, 32'h1); rd({2'h0, CCR_IDX_LOAD_CTL, 2'h0}, 34'h1);
		chk(frb, 32'h0);
		repeat (30) @(posedge clk);
		chk(frb, 32'h1);
		wr(CCR_IDX_LOAD_DAT, 32'hFF04); rd({2'h0, CCR_IDX_LOAD_CTL, 2'h0}, 34'h2);
		rd({2'h0, CCR_IDX_LOAD_DAT, 2'h0}, {32'h0, r[1:0]});
		repeat (200) @(posedge clk);
		chk(cw, 32'hFF04);
		rd({2'h0, CCR_IDX_LOAD_CTL, 2'h0}, 34'h0);
		wr(CCR_IDX_RCW, 32'h1000); repeat (200) @(posedge clk);
		chk({rw, oe}, {15'h0, 16'h1000, 1'b0});
		wr(CCR_IDX_RCW, 32'h0); repeat (200) @(posedge clk);
		chk({rw, oe}, 32'h1);
		rd(8'hFC, {CCR_RESP_SLVERR, 32'h0});
		$display("load and unmapped done");
		complete_run();
	end
endmodule : tb_correlator_card_control_regs
